// ===== verilog/iacl_cfg.svh
// constants for the ip filter_list frame classifier
`ifndef IACL_CFG_SVH
`define IACL_CFG_SVH
`define IACL_NUM_ENTRIES 8
`define IACL_NUM_PORTS 8
`define IACL_NUM_LISTS 4
`define IACL_ENT_W 3
`define IACL_PORT_W 3
`define IACL_LIST_W 2
// register offsets (byte addresses)
`define IACL_OFF_SEL 8'h00
`define IACL_OFF_CTRL 8'h04
`define IACL_OFF_KEY0 8'h08
`define IACL_OFF_KEY1 8'h0c
`define IACL_OFF_SIP 8'h10
`define IACL_OFF_SIPM 8'h14
`define IACL_OFF_DIP 8'h18
`define IACL_OFF_DIPM 8'h1c
`define IACL_OFF_SPR 8'h20
`define IACL_OFF_DPR 8'h24
`define IACL_OFF_BIND 8'h28
`define IACL_OFF_STAT 8'h2c
// ctrl fields
`define IACL_CTRL_VALID 0
`define IACL_CTRL_ACT 1
`define IACL_CTRL_LIST_LO 2
`define IACL_CTRL_SEQ_LO 8
// key0 fields: syn[1:0] fin[3:2] tos_mode[5:4] tos_val[13:8] proto[23:16]
`define IACL_K0_SYN_LO 0
`define IACL_K0_FIN_LO 2
`define IACL_K0_TOS_LO 4
`define IACL_K0_TOSV_LO 8
`define IACL_K0_PROTO_LO 16
`define IACL_K0_PROTOEN 24
// key1 fields: icmp_mode[1:0] code_mode[2] type[15:8] code[23:16]
`define IACL_K1_ICMP_LO 0
`define IACL_K1_CODEEN 2
`define IACL_K1_TYPE_LO 8
`define IACL_K1_CODE_LO 16
// bind fields: mac[2:0] v4[6:4] v6[10:8]; bit2/6/10 = bound
`define IACL_BIND_V6_LO 8
// icmp type list (list mode index -> type)
`define IACL_ICMP_LIST {8'h00, 8'h03, 8'h05, 8'h08, 8'h0b, 8'h80, 8'h81, 8'h87}
`endif

// ===== verilog/iacl_pkg.sv
// types for the ip filter_list frame classifier
`default_nettype none
package iacl_pkg;
   typedef enum logic [1:0] {
      IACL_FLAG_DC = 2'h0, IACL_FLAG_SET = 2'h1, IACL_FLAG_UNSET = 2'h2
   } iacl_flag_t;
   typedef enum logic [1:0] {
      IACL_TOS_ANY = 2'h0, IACL_TOS_DSCP = 2'h1, IACL_TOS_PREC = 2'h2
   } iacl_tos_t;
   typedef enum logic [1:0] {
      IACL_ICMP_ANY = 2'h0, IACL_ICMP_LIST = 2'h1, IACL_ICMP_PROTO = 2'h2
   } iacl_icmp_t;
   typedef enum logic [1:0] {
      IACL_ST_IDLE = 2'h0, IACL_ST_SCAN = 2'h1, IACL_ST_DONE = 2'h3
   } iacl_state_t;
endpackage
`default_nettype wire

// ===== verilog/iacl_classifier.sv
// ip filter_list frame classifier with axi4-lite configuration
`include "iacl_cfg.svh"
`default_nettype none
module iacl_classifier (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // parsed header request
   input wire logic hdr_valid_in,
   output logic hdr_ready_out,
   input wire logic [2:0] hdr_port_in,
   input wire logic hdr_is_tcp_in,
   input wire logic hdr_is_icmp_in,
   input wire logic hdr_syn_in,
   input wire logic hdr_fin_in,
   input wire logic [5:0] hdr_dscp_in,
   input wire logic [7:0] hdr_proto_in,
   input wire logic [7:0] hdr_icmp_type_in,
   input wire logic [7:0] hdr_icmp_code_in,
   input wire logic [31:0] hdr_sip_in,
   input wire logic [31:0] hdr_dip_in,
   input wire logic [15:0] hdr_sport_in,
   input wire logic [15:0] hdr_dport_in,
   // verdict
   output logic res_valid_out,
   output logic res_hit_out,
   output logic res_deny_out,
   output logic [2:0] res_entry_out
);
   localparam int NE = `IACL_NUM_ENTRIES;
   localparam logic [63:0] ICMP_LIST = `IACL_ICMP_LIST;

   // entry store
   logic [31:0] ctrl_reg [NE], ctrl_next [NE];
   logic [31:0] key0_reg [NE], key0_next [NE];
   logic [31:0] key1_reg [NE], key1_next [NE];
   logic [31:0] sip_reg [NE], sip_next [NE];
   logic [31:0] sipm_reg [NE], sipm_next [NE];
   logic [31:0] dip_reg [NE], dip_next [NE];
   logic [31:0] dipm_reg [NE], dipm_next [NE];
   logic [31:0] spr_reg [NE], spr_next [NE];
   logic [31:0] dpr_reg [NE], dpr_next [NE];
   logic [11:0] bind_reg [`IACL_NUM_PORTS], bind_next [`IACL_NUM_PORTS];
   logic [2:0] sel_reg, sel_next;
   logic [31:0] hits_reg, hits_next;

   // bus state
   logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
   logic [7:0] aw_addr_reg, aw_addr_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;

   // flag condition check
   function automatic logic flag_ok(input logic [1:0] c, input logic f);
      case (c)
         iacl_pkg::IACL_FLAG_SET: flag_ok = f;
         iacl_pkg::IACL_FLAG_UNSET: flag_ok = !f;
         default: flag_ok = 1'b1;
      endcase
   endfunction

   // byte lanes of the held write word laid over the old value
   function automatic logic [31:0] wm(input logic [31:0] o);
      for (int b = 0; b < 4; b++) begin
         wm[b*8 +: 8] = w_strb_reg[b] ? w_data_reg[b*8 +: 8] : o[b*8 +: 8];
      end
   endfunction

   // per-entry match, all fields must agree
   logic [NE-1:0] ent_hit;
   logic [7:0] seq_w [NE];
   genvar g;
   generate
      for (g = 0; g < NE; g++) begin : g_ent
         logic [31:0] k0, k1;
         logic tos_ok, icmp_ok, code_ok, fl_ok, ip_ok, pr_ok, bnd_ok;
         logic [1:0] lst;
         assign k0 = key0_reg[g];
         assign k1 = key1_reg[g];
         assign lst = ctrl_reg[g][`IACL_CTRL_LIST_LO +: 2];
         assign seq_w[g] = ctrl_reg[g][`IACL_CTRL_SEQ_LO +: 8];
         assign fl_ok = !hdr_is_tcp_in ||
            (flag_ok(k0[`IACL_K0_SYN_LO +: 2], hdr_syn_in) &&
             flag_ok(k0[`IACL_K0_FIN_LO +: 2], hdr_fin_in));
         always_comb begin
            case (k0[`IACL_K0_TOS_LO +: 2])
               iacl_pkg::IACL_TOS_DSCP:
                  tos_ok = hdr_dscp_in == k0[`IACL_K0_TOSV_LO +: 6];
               iacl_pkg::IACL_TOS_PREC:
                  tos_ok = hdr_dscp_in[5:3] ==
                     k0[`IACL_K0_TOSV_LO +: 3];
               default: tos_ok = 1'b1;
            endcase
            case (k1[`IACL_K1_ICMP_LO +: 2])
               iacl_pkg::IACL_ICMP_LIST:
                  icmp_ok = hdr_is_icmp_in && hdr_icmp_type_in ==
                     ICMP_LIST[k1[`IACL_K1_TYPE_LO +: 3]*8 +: 8];
               iacl_pkg::IACL_ICMP_PROTO:
                  icmp_ok = hdr_proto_in ==
                     k1[`IACL_K1_TYPE_LO +: 8];
               default: icmp_ok = 1'b1;
            endcase
         end
         assign code_ok = !k1[`IACL_K1_CODEEN] ||
            (hdr_is_icmp_in &&
             hdr_icmp_code_in == k1[`IACL_K1_CODE_LO +: 8]);
         assign pr_ok = (!k0[`IACL_K0_PROTOEN] ||
            hdr_proto_in == k0[`IACL_K0_PROTO_LO +: 8]) &&
            hdr_sport_in >= spr_reg[g][15:0] &&
            hdr_sport_in <= spr_reg[g][31:16] &&
            hdr_dport_in >= dpr_reg[g][15:0] &&
            hdr_dport_in <= dpr_reg[g][31:16];
         assign ip_ok = (((hdr_sip_in ^ sip_reg[g]) & ~sipm_reg[g]) == 0) &&
            (((hdr_dip_in ^ dip_reg[g]) & ~dipm_reg[g]) == 0);
         // v6 slot only; mac/v4 slots held for other classifiers
         assign bnd_ok = bind_reg[hdr_port_in][`IACL_BIND_V6_LO + 2] &&
            bind_reg[hdr_port_in][`IACL_BIND_V6_LO +: 2] == lst;
         assign ent_hit[g] = ctrl_reg[g][`IACL_CTRL_VALID] && fl_ok &&
            tos_ok && icmp_ok && code_ok && pr_ok && ip_ok && bnd_ok;
      end
   endgenerate

   // lowest sequence among hitting entries
   logic any_hit;
   logic [2:0] best;
   always_comb begin
      any_hit = 1'b0;
      best = 3'h0;
      for (int i = 0; i < NE; i++) begin
         if (ent_hit[i] && (!any_hit || seq_w[i] < seq_w[best])) begin
            any_hit = 1'b1;
            best = 3'(i);
         end
      end
   end

   // verdict pipeline: idle -> scan -> done
   iacl_pkg::iacl_state_t st_reg, st_next;
   logic hit_reg, hit_next, deny_reg, deny_next;
   logic [2:0] ent_reg, ent_next;
   always_comb begin
      st_next = st_reg;
      hit_next = hit_reg;
      deny_next = deny_reg;
      ent_next = ent_reg;
      case (st_reg)
         iacl_pkg::IACL_ST_IDLE: if (hdr_valid_in) begin
            st_next = iacl_pkg::IACL_ST_SCAN;
            hit_next = any_hit;
            ent_next = best;
            deny_next = any_hit && !ctrl_reg[best][`IACL_CTRL_ACT];
         end
         iacl_pkg::IACL_ST_SCAN: st_next = iacl_pkg::IACL_ST_DONE;
         default: st_next = iacl_pkg::IACL_ST_IDLE;
      endcase
   end

   // bus decode, writes and reads
   logic do_wr, do_rd;
   assign do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
   assign do_rd = s_axi_arvalid_in && !rvalid_reg;
   always_comb begin
      for (int i = 0; i < NE; i++) begin
         ctrl_next[i] = ctrl_reg[i]; key0_next[i] = key0_reg[i];
         key1_next[i] = key1_reg[i]; sip_next[i] = sip_reg[i];
         sipm_next[i] = sipm_reg[i]; dip_next[i] = dip_reg[i];
         dipm_next[i] = dipm_reg[i]; spr_next[i] = spr_reg[i];
         dpr_next[i] = dpr_reg[i];
      end
      bind_next = bind_reg;
      sel_next = sel_reg;
      hits_next = hits_reg + 32'((st_reg == iacl_pkg::IACL_ST_DONE) &&
         hit_reg);
      aw_full_next = aw_full_reg || s_axi_awvalid_in;
      aw_addr_next = aw_full_reg ? aw_addr_reg : s_axi_awaddr_in;
      w_full_next = w_full_reg || s_axi_wvalid_in;
      w_data_next = w_full_reg ? w_data_reg : s_axi_wdata_in;
      w_strb_next = w_full_reg ? w_strb_reg : s_axi_wstrb_in;
      bvalid_next = bvalid_reg && !s_axi_bready_in;
      bresp_next = bresp_reg;
      if (do_wr) begin
         aw_full_next = 1'b0;
         w_full_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = 2'h0;
         case (aw_addr_reg)
            `IACL_OFF_SEL: sel_next = w_data_reg[2:0];
            `IACL_OFF_CTRL: ctrl_next[sel_reg] = wm(ctrl_reg[sel_reg]);
            `IACL_OFF_KEY0: key0_next[sel_reg] = wm(key0_reg[sel_reg]);
            `IACL_OFF_KEY1: key1_next[sel_reg] = wm(key1_reg[sel_reg]);
            `IACL_OFF_SIP: sip_next[sel_reg] = wm(sip_reg[sel_reg]);
            `IACL_OFF_SIPM: sipm_next[sel_reg] = wm(sipm_reg[sel_reg]);
            `IACL_OFF_DIP: dip_next[sel_reg] = wm(dip_reg[sel_reg]);
            `IACL_OFF_DIPM: dipm_next[sel_reg] = wm(dipm_reg[sel_reg]);
            `IACL_OFF_SPR: spr_next[sel_reg] = wm(spr_reg[sel_reg]);
            `IACL_OFF_DPR: dpr_next[sel_reg] = wm(dpr_reg[sel_reg]);
            // bind slots indexed by sel as port number
            `IACL_OFF_BIND: bind_next[sel_reg] = w_data_reg[11:0];
            `IACL_OFF_STAT: hits_next = hits_next - hits_reg; // hit wins
            default: bresp_next = 2'h2;
         endcase
      end
      rvalid_next = rvalid_reg && !s_axi_rready_in;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (do_rd) begin
         rvalid_next = 1'b1;
         rresp_next = 2'h0;
         rdata_next = 32'h0;
         case (s_axi_araddr_in)
            `IACL_OFF_SEL: rdata_next = {29'h0, sel_reg};
            `IACL_OFF_CTRL: rdata_next = ctrl_reg[sel_reg];
            `IACL_OFF_KEY0: rdata_next = key0_reg[sel_reg];
            `IACL_OFF_KEY1: rdata_next = key1_reg[sel_reg];
            `IACL_OFF_SIP: rdata_next = sip_reg[sel_reg];
            `IACL_OFF_SIPM: rdata_next = sipm_reg[sel_reg];
            `IACL_OFF_DIP: rdata_next = dip_reg[sel_reg];
            `IACL_OFF_DIPM: rdata_next = dipm_reg[sel_reg];
            `IACL_OFF_SPR: rdata_next = spr_reg[sel_reg];
            `IACL_OFF_DPR: rdata_next = dpr_reg[sel_reg];
            `IACL_OFF_BIND: rdata_next = {20'h0, bind_reg[sel_reg]};
            `IACL_OFF_STAT: rdata_next = hits_reg;
            default: rresp_next = 2'h2;
         endcase
      end
   end

   // all state registered; empty entries never hit
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < NE; i++) begin
            ctrl_reg[i] <= 32'h0; key0_reg[i] <= 32'h0;
            key1_reg[i] <= 32'h0; sip_reg[i] <= 32'h0;
            sipm_reg[i] <= 32'h0; dip_reg[i] <= 32'h0;
            dipm_reg[i] <= 32'h0; spr_reg[i] <= 32'hffff0000;
            dpr_reg[i] <= 32'hffff0000;
         end
         bind_reg <= '{default: 12'h0};
         sel_reg <= 3'h0; hits_reg <= 32'h0;
         aw_full_reg <= 1'b0; w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h0; w_data_reg <= 32'h0; w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0; rvalid_reg <= 1'b0;
         bresp_reg <= 2'h0; rresp_reg <= 2'h0; rdata_reg <= 32'h0;
         st_reg <= iacl_pkg::IACL_ST_IDLE;
         hit_reg <= 1'b0; deny_reg <= 1'b0; ent_reg <= 3'h0;
      end else begin
         ctrl_reg <= ctrl_next; key0_reg <= key0_next;
         key1_reg <= key1_next; sip_reg <= sip_next;
         sipm_reg <= sipm_next; dip_reg <= dip_next;
         dipm_reg <= dipm_next; spr_reg <= spr_next;
         dpr_reg <= dpr_next; bind_reg <= bind_next;
         sel_reg <= sel_next; hits_reg <= hits_next;
         aw_full_reg <= aw_full_next; w_full_reg <= w_full_next;
         aw_addr_reg <= aw_addr_next; w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         bvalid_reg <= bvalid_next; rvalid_reg <= rvalid_next;
         bresp_reg <= bresp_next; rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         st_reg <= st_next;
         hit_reg <= hit_next; deny_reg <= deny_next; ent_reg <= ent_next;
      end
   end

   // outputs straight from flops
   assign s_axi_awready_out = !aw_full_reg;
   assign s_axi_wready_out = !w_full_reg;
   assign s_axi_bvalid_out = bvalid_reg;
   assign s_axi_bresp_out = bresp_reg;
   assign s_axi_arready_out = !rvalid_reg;
   assign s_axi_rvalid_out = rvalid_reg;
   assign s_axi_rdata_out = rdata_reg;
   assign s_axi_rresp_out = rresp_reg;
   assign hdr_ready_out = st_reg == iacl_pkg::IACL_ST_IDLE;
   assign res_valid_out = st_reg == iacl_pkg::IACL_ST_DONE;
   assign res_hit_out = hit_reg;
   assign res_deny_out = deny_reg;
   assign res_entry_out = ent_reg;

   // checks
   no_hit_fwd_a: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) res_valid_out && !res_hit_out |->
      !res_deny_out) else $error("deny without hit");
   verdict_lat_a: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) hdr_valid_in && hdr_ready_out |->
      ##2 res_valid_out) else $error("verdict late");
   hit_valid_a: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) hdr_valid_in && hdr_ready_out && any_hit
      |-> ent_hit[best] && (!ent_hit[0] || seq_w[best] <= seq_w[0]))
      else $error("chosen entry not first in order");
   mask_cmp_a: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) ent_hit[0] |->
      ((hdr_sip_in ^ sip_reg[0]) & ~sipm_reg[0]) == 32'h0)
      else $error("masked address mismatch hit");
   range_a: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) ent_hit[0] |->
      hdr_dport_in <= dpr_reg[0][31:16]) else $error("port above range");
   bind_a: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) ent_hit[0] |->
      bind_reg[hdr_port_in][10]) else $error("unbound port hit");
   syn_a: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) ent_hit[0] && hdr_is_tcp_in &&
      key0_reg[0][1:0] == 2'h2 |-> !hdr_syn_in)
      else $error("syn unset hit");
   bresp_a: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) do_wr && aw_addr_reg == `IACL_OFF_BIND
      |=> s_axi_bvalid_out && s_axi_bresp_out == 2'h0)
      else $error("bind write not answered");
   hit_cv: cover property (@(posedge sys_clk_in) res_valid_out && res_hit_out);
   miss_cv: cover property (@(posedge sys_clk_in) res_valid_out && !hit_reg);
   deny_cv: cover property (@(posedge sys_clk_in) res_valid_out && deny_reg);
endmodule // iacl_classifier
`default_nettype wire

// ===== sim/iacl_hdr_src.sv
// ingress header source model facing the classifier
`default_nettype none
module iacl_hdr_src (
   // clock
   input wire logic clk_in,
   // header handshake
   input wire logic ready_in,
   output var logic valid_out,
   output var logic [132:0] fields_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle before any frame
   initial begin
      valid_out = 1'b0;
      fields_out = '0;
   end

   // hold valid and fields until an edge samples ready high
   task automatic send(input logic [132:0] f, output bit ok);
      int n;
      ok = 1'b0;
      @(posedge clk_in);
      valid_out <= 1'b1;
      fields_out <= f;
      for (n = 0; n < 40 && !ok; n++) begin
         @(posedge clk_in);
         ok = (ready_in === 1'b1);
      end
      // released fields show junk so stale values cannot pass
      valid_out <= 1'b0;
      fields_out <= ~f;
   endtask
endmodule // iacl_hdr_src
`default_nettype wire

// ===== sim/test_ip_acl_frame_classifier.sv
// self-checking bench for the ip filter_list frame classifier
`include "iacl_cfg.svh"
`default_nettype none
module test_ip_acl_frame_classifier;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
   logic [31:0] w_data = 32'h0, r_data;
   logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
   logic ar_valid = 1'b0, r_ready = 1'b0;
   logic aw_ready, w_ready, b_valid, ar_ready, r_valid, hv, hr;
   logic [1:0] b_resp, r_resp;
   logic [1:0] b_last = 2'h0;
   logic [132:0] hf;
   logic res_valid, res_hit, res_deny;
   logic [2:0] res_ent;
   logic [31:0] f_sip = 32'h0, f_dip = 32'h0;
   logic [15:0] f_sp = 16'h0, f_dp = 16'h0;
   int num_errors = 0;
   int tests_run = 0;

   // 100 ns clock
   always #50 sys_clk_in = ~sys_clk_in;

   // design under test; byte strobes tied full
   iacl_classifier i_iacl_classifier (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid),
      .s_axi_awready_out(aw_ready), .s_axi_wdata_in(w_data),
      .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_valid),
      .s_axi_wready_out(w_ready), .s_axi_bresp_out(b_resp),
      .s_axi_bvalid_out(b_valid), .s_axi_bready_in(b_ready),
      .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid),
      .s_axi_arready_out(ar_ready), .s_axi_rdata_out(r_data),
      .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_valid),
      .s_axi_rready_in(r_ready), .hdr_valid_in(hv), .hdr_ready_out(hr),
      .hdr_port_in(hf[132:130]), .hdr_is_tcp_in(hf[129]),
      .hdr_is_icmp_in(hf[128]), .hdr_syn_in(hf[127]), .hdr_fin_in(hf[126]),
      .hdr_dscp_in(hf[125:120]), .hdr_proto_in(hf[119:112]),
      .hdr_icmp_type_in(hf[111:104]), .hdr_icmp_code_in(hf[103:96]),
      .hdr_sip_in(hf[95:64]), .hdr_dip_in(hf[63:32]),
      .hdr_sport_in(hf[31:16]), .hdr_dport_in(hf[15:0]),
      .res_valid_out(res_valid), .res_hit_out(res_hit),
      .res_deny_out(res_deny), .res_entry_out(res_ent));

   iacl_hdr_src i_iacl_hdr_src (.clk_in(sys_clk_in), .ready_in(hr),
      .valid_out(hv), .fields_out(hf));

   // verdict and end of run
   task automatic close_out();
      $display("errors %0d, checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, exp, input string m);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
      end
   endtask

   // a wait that ran out ends the run
   task automatic hang(input string m);
      num_errors++;
      $display("[FAIL] %0t %s timed out", $time, m);
      close_out();
   endtask

   // address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      bit done;
      done = 1'b0;
      @(posedge sys_clk_in);
      aw_addr <= a;
      w_data <= d;
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      for (n = 0; n < 40 && !done; n++) begin
         @(posedge sys_clk_in);
         if (aw_ready) aw_valid <= 1'b0;
         if (w_ready) w_valid <= 1'b0;
         if (b_valid) begin
            done = 1'b1;
            b_last = b_resp;
            b_ready <= 1'b0;
         end
      end
      if (!done) hang("write");
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int n;
      bit done;
      done = 1'b0;
      @(posedge sys_clk_in);
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      for (n = 0; n < 40 && !done; n++) begin
         @(posedge sys_clk_in);
         if (ar_ready) ar_valid <= 1'b0;
         if (r_valid) begin
            done = 1'b1;
            d = r_data;
            r = r_resp;
            r_ready <= 1'b0;
         end
      end
      if (!done) hang("read");
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      cmp(d, e, "read data");
      cmp({30'h0, r}, 32'h0, "read resp");
   endtask

   // entry with open addresses and full port ranges
   task automatic ent(input logic [2:0] i, input logic [31:0] c, k0, k1);
      axw(`IACL_OFF_SEL, {29'h0, i});
      axw(`IACL_OFF_CTRL, c);
      axw(`IACL_OFF_KEY0, k0);
      axw(`IACL_OFF_KEY1, k1);
      axw(`IACL_OFF_SIPM, 32'hffffffff);
      axw(`IACL_OFF_DIPM, 32'hffffffff);
      axw(`IACL_OFF_SPR, 32'hffff0000);
      axw(`IACL_OFF_DPR, 32'hffff0000);
   endtask

   task automatic bnd(input logic [2:0] p, input logic [31:0] v);
      axw(`IACL_OFF_SEL, {29'h0, p});
      axw(`IACL_OFF_BIND, v);
   endtask

   // fl = {tcp, icmp, syn, fin}; w = {hit, deny, entry}
   task automatic frm(input logic [2:0] p, input logic [3:0] fl,
      input logic [5:0] ds, input logic [7:0] pr, ty, co,
      input logic [4:0] w);
      int n;
      bit ok;
      i_iacl_hdr_src.send({p, fl, ds, pr, ty, co, f_sip, f_dip, f_sp, f_dp},
         ok);
      if (!ok) hang("header");
      ok = 1'b0;
      for (n = 0; n < 10 && !ok; n++) begin
         @(posedge sys_clk_in);
         ok = (res_valid === 1'b1);
      end
      if (!ok) hang("verdict");
      cmp({27'h0, res_hit, res_deny, res_ent}, {27'h0, w}, "verdict");
   endtask

   task automatic ft(input logic [2:0] p, input logic [3:0] fl,
      input logic [4:0] w);
      frm(p, fl, 6'h00, 8'h06, 8'h00, 8'h00, w);
   endtask

   // reset values, unmapped place, key readback
   task automatic s_regs();
      logic [31:0] d;
      logic [1:0] r;
      rdchk(`IACL_OFF_CTRL, 32'h0);
      rdchk(`IACL_OFF_SPR, 32'hffff0000);
      axr(8'h30, d, r);
      cmp({30'h0, r}, 32'h2, "unmapped resp");
      cmp(d, 32'h0, "unmapped data");
      axw(`IACL_OFF_KEY0, 32'h01062e15);
      cmp({30'h0, b_last}, 32'h0, "write resp");
      rdchk(`IACL_OFF_KEY0, 32'h01062e15);
      axw(8'h30, 32'h1);
      cmp({30'h0, b_last}, 32'h2, "unmapped write resp");
   endtask

   task automatic s_flags();
      bnd(3'h2, 32'h00000500);
      ent(3'h0, 32'h00000a07, 32'h00000009, 32'h0);
      ft(3'h2, 4'ha, 5'h10);
      ft(3'h2, 4'h8, 5'h00);
      ft(3'h2, 4'hb, 5'h00);
      axw(`IACL_OFF_KEY0, 32'h00000004);
      ft(3'h2, 4'h9, 5'h10);
      ft(3'h2, 4'h8, 5'h00);
      ft(3'h2, 4'hb, 5'h10);
      axw(`IACL_OFF_KEY0, 32'h0);
      ft(3'h2, 4'h8, 5'h10);
      ft(3'h3, 4'h8, 5'h00);
      bnd(3'h3, 32'h00000050);
      ft(3'h3, 4'h8, 5'h00);
      axw(`IACL_OFF_BIND, 32'h00000550);
      ft(3'h3, 4'h8, 5'h10);
      rdchk(`IACL_OFF_BIND, 32'h00000550);
   endtask

   task automatic s_tos();
      ent(3'h0, 32'h00000a07, 32'h00002e10, 32'h0);
      frm(3'h2, 4'h8, 6'h2e, 8'h06, 8'h00, 8'h00, 5'h10);
      frm(3'h2, 4'h8, 6'h2f, 8'h06, 8'h00, 8'h00, 5'h00);
      axw(`IACL_OFF_KEY0, 32'h00000520);
      frm(3'h2, 4'h8, 6'h2f, 8'h06, 8'h00, 8'h00, 5'h10);
      frm(3'h2, 4'h8, 6'h20, 8'h06, 8'h00, 8'h00, 5'h00);
      axw(`IACL_OFF_KEY0, 32'h00003f00);
      frm(3'h2, 4'h8, 6'h2e, 8'h06, 8'h00, 8'h00, 5'h10);
   endtask

   task automatic s_icmp();
      ent(3'h0, 32'h00000a07, 32'h01ff0000, 32'h00ff5504);
      frm(3'h2, 4'h4, 6'h00, 8'hff, 8'h08, 8'hff, 5'h10);
      frm(3'h2, 4'h4, 6'h00, 8'hff, 8'h08, 8'hfe, 5'h00);
      frm(3'h2, 4'h4, 6'h00, 8'hfe, 8'h08, 8'hff, 5'h00);
      axw(`IACL_OFF_KEY1, 32'h0);
      frm(3'h2, 4'h4, 6'h00, 8'hff, 8'h22, 8'h09, 5'h10);
      axw(`IACL_OFF_KEY0, 32'h0);
      // list index 4 picks type 08 from the fixed table
      axw(`IACL_OFF_KEY1, 32'h00000401);
      frm(3'h2, 4'h4, 6'h00, 8'h01, 8'h08, 8'h00, 5'h10);
      frm(3'h2, 4'h4, 6'h00, 8'h01, 8'h03, 8'h00, 5'h00);
      axw(`IACL_OFF_KEY1, 32'h00001102);
      frm(3'h2, 4'h4, 6'h00, 8'h11, 8'h00, 8'h00, 5'h10);
      frm(3'h2, 4'h4, 6'h00, 8'h12, 8'h00, 8'h00, 5'h00);
   endtask

   task automatic s_addr();
      logic [96:0] tb [7];
      int i;
      logic h;
      tb = '{{32'h0a0001ab, 32'hc0a80001, 16'h1000, 16'h0050, 1'b1},
         {32'h0a0001ab, 32'hc0a80001, 16'h2000, 16'h0050, 1'b1},
         {32'h0a0001ab, 32'hc0a80001, 16'h2001, 16'h0050, 1'b0},
         {32'h0a0001ab, 32'hc0a80001, 16'h0fff, 16'h0050, 1'b0},
         {32'h0a0001ab, 32'hc0a80001, 16'h1000, 16'h0051, 1'b0},
         {32'h0a0002ab, 32'hc0a80001, 16'h1000, 16'h0050, 1'b0},
         {32'h0a0001ab, 32'hc0a80003, 16'h1000, 16'h0050, 1'b0}};
      ent(3'h0, 32'h00000a07, 32'h0, 32'h0);
      axw(`IACL_OFF_SIP, 32'h0a000100);
      axw(`IACL_OFF_SIPM, 32'h000000ff);
      axw(`IACL_OFF_DIP, 32'hc0a80001);
      axw(`IACL_OFF_DIPM, 32'h0);
      axw(`IACL_OFF_SPR, 32'h20001000);
      axw(`IACL_OFF_DPR, 32'h00500050);
      for (i = 0; i < 7; i++) begin
         {f_sip, f_dip, f_sp, f_dp, h} = tb[i];
         ft(3'h2, 4'h8, {h, 4'h0});
      end
   endtask

   // lowest sequence wins, ties to the lower index, misses forward
   task automatic s_order();
      ent(3'h0, 32'h00001405, 32'h0, 32'h0);
      ent(3'h1, 32'h00000507, 32'h0, 32'h0);
      ft(3'h2, 4'h8, 5'h11);
      rdchk(`IACL_OFF_CTRL, 32'h00000507);
      axw(`IACL_OFF_CTRL, 32'h00001407);
      ft(3'h2, 4'h8, 5'h18);
      rdchk(`IACL_OFF_STAT, 32'h00000010);
      axw(`IACL_OFF_STAT, 32'h0);
      rdchk(`IACL_OFF_STAT, 32'h0);
      axw(`IACL_OFF_CTRL, 32'h0);
      axw(`IACL_OFF_SEL, 32'h0);
      axw(`IACL_OFF_CTRL, 32'h0);
      ft(3'h2, 4'h8, 5'h00);
   endtask

   // reset for six cycles, then each scenario in turn
   initial begin
      repeat (6) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      s_regs();
      s_flags();
      s_tos();
      s_icmp();
      s_addr();
      s_order();
      close_out();
   end
endmodule // test_ip_acl_frame_classifier
`default_nettype wire
